// ==== src/ilr_pkg.sv ====
// Package: register offsets, field layout, reset values and scaling for the input limit registers
package ilr_pkg;
    // Register indices (byte-wide command codes of the management bus)
    localparam logic [7:0] ILR_APPLIED_CAP_OFS = 8'h22;
    localparam logic [7:0] ILR_VIN_FLOOR_OFS = 8'h3d;
    localparam logic [7:0] ILR_HOST_CAP_OFS = 8'h3f;
    // Current field: bits 14..8, voltage field: bits 13..6
    localparam int ILR_CUR_LSB = 8;
    localparam int ILR_CUR_MSB = 14;
    localparam int ILR_VIN_LSB = 6;
    localparam int ILR_VIN_MSB = 13;
    localparam logic [6:0] ILR_HOST_CAP_RST = 7'h40;
    localparam logic [6:0] ILR_APPLIED_CAP_RST = 7'h00;
    // Reserved upper bits that must be written as zero
    localparam logic [15:0] ILR_CUR_RSV_HI = 16'h8000;
    localparam logic [15:0] ILR_VIN_RSV_HI = 16'hc000;
    // Scaling in mA and mV
    localparam logic [15:0] ILR_CUR_STEP_MA = 16'h0032;
    localparam logic [15:0] ILR_CUR_OFS_MA = 16'h0032;
    localparam logic [15:0] ILR_VIN_STEP_MV = 16'h0040;
    localparam logic [15:0] ILR_VIN_OFS_MV = 16'h0c80;
    localparam logic [15:0] ILR_VIN_DEFAULT_DROP_MV = 16'h0500;
endpackage : ilr_pkg

// ==== src/ilr_weight_sum.sv ====
// Weighted field decoder: sum of set-bit weights plus a fixed offset
`timescale 1ns/10ps
`default_nettype none
module ilr_weight_sum #(
    parameter int W = 7
) (
    input wire logic [W-1:0] i_code,
    input wire logic [15:0] i_lsb_weight,
    input wire logic [15:0] i_offset,
    output logic [15:0] o_value
);
    logic [15:0] part [W+1];
    assign part[0] = i_offset;
    // One adder per field bit, each bit weighing double the one below
    for (genvar g = 0; g < W; g++) begin : g_bit
        assign part[g+1] = part[g] + (i_code[g] ? 16'(i_lsb_weight << g) : 16'h0000);
    end
    assign o_value = part[W];
endmodule : ilr_weight_sum
`default_nettype wire

// ==== src/ilr_regs.sv ====
// Input current cap and input voltage floor register set with dynamic power management flag
// Operation
// [RULE1] Host cap is 7 bits, 50 mA weighting
// [RULE2] Host cap resets to top bit set
// [RULE3] Reserved high bit set means write refused
// [RULE4] Reserved low bits ignored, read zero
// [RULE5] Read-only register reports applied current cap
// [RULE6] Optimizer value applied, host register untouched
// [RULE7] Applied cap same field, read-only, resets zero
// [RULE8] Current code zero means 50 mA
// [RULE9] Voltage floor 8 bits, 64 mV weighting
// [RULE10] Voltage floor adds 3.2 V offset
// [RULE11] Unprogrammed floor is supply minus 1.28 V
// [RULE12] Below floor: enter power management, cut charge; the code only raises o_power_mgmt_active and has no charge path
// [RULE13] Host writes floor as one 16-bit word
// [RULE14] Adapter removal restores 3.3 A host cap; the code reloads code 0x40, which decodes to 3250 mA
// [RULE15] Effective limits update when write completes
`timescale 1ns/10ps
`default_nettype none
module ilr_regs
    import ilr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_cmd,
    input wire logic [15:0] i_wr_data,
    input wire logic [7:0] i_rd_cmd,
    output logic [15:0] o_rd_data,
    output logic o_wr_invalid,
    input wire logic i_opt_valid,
    input wire logic [6:0] i_opt_code,
    input wire logic i_adapter_present,
    input wire logic [15:0] i_vsupply_noload_mv,
    input wire logic [15:0] i_vsupply_mv,
    output logic [15:0] o_current_cap_ma,
    output logic [15:0] o_vin_floor_mv,
    output logic o_power_mgmt_active
);
    logic [6:0] host_cap_r;
    logic [6:0] applied_cap_r;
    logic [7:0] vin_code_r;
    logic vin_set_r;
    logic adapter_r;
    logic [15:0] rd_data_r;
    logic invalid_r;
    logic [15:0] cap_ma_r;
    logic [15:0] floor_mv_r;
    logic pm_r;
    logic [15:0] cap_ma_nxt;
    logic [15:0] floor_prog_mv;
    logic [15:0] floor_mv_nxt;
    logic wr_host;
    logic wr_vin;
    logic host_ok;
    logic vin_ok;

    // Write decode; a one in a reserved high bit refuses the whole word
    assign wr_host = i_wr_en && (i_wr_cmd == ILR_HOST_CAP_OFS);
    assign wr_vin = i_wr_en && (i_wr_cmd == ILR_VIN_FLOOR_OFS);
    assign host_ok = (i_wr_data & ILR_CUR_RSV_HI) == 16'h0000; // [RULE3]
    assign vin_ok = (i_wr_data & ILR_VIN_RSV_HI) == 16'h0000; // [RULE3]

    // Adapter presence, registered to spot its falling edge
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            adapter_r <= 1'b0;
        end else begin
            adapter_r <= i_adapter_present;
        end
    end

    // Host cap; only bits 14..8 are stored, low byte dropped
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            host_cap_r <= ILR_HOST_CAP_RST; // [RULE2]
        end else if (adapter_r && !i_adapter_present) begin
            host_cap_r <= ILR_HOST_CAP_RST; // [RULE14]
        end else if (wr_host && host_ok) begin
            host_cap_r <= i_wr_data[ILR_CUR_MSB:ILR_CUR_LSB]; // [RULE1] [RULE4]
        end
    end

    // Applied cap takes each accepted host write, and a valid optimizer code wins; it keeps its value on adapter removal
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            applied_cap_r <= ILR_APPLIED_CAP_RST; // [RULE7]
        end else if (i_opt_valid) begin
            applied_cap_r <= i_opt_code; // [RULE6]
        end else if (wr_host && host_ok) begin
            applied_cap_r <= i_wr_data[ILR_CUR_MSB:ILR_CUR_LSB]; // [RULE5]
        end
    end

    // Voltage floor; vin_set_r marks that software has programmed it
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            vin_code_r <= 8'h00;
            vin_set_r <= 1'b0;
        end else if (wr_vin && vin_ok) begin
            vin_code_r <= i_wr_data[ILR_VIN_MSB:ILR_VIN_LSB]; // [RULE9] [RULE4] [RULE13]
            vin_set_r <= 1'b1;
        end
    end

    // Refused-write flag, one cycle per bad write
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            invalid_r <= 1'b0;
        end else begin
            invalid_r <= (wr_host && !host_ok) || (wr_vin && !vin_ok); // [RULE3]
        end
    end

    // Readback; registered so data stays stable for the bus shifter
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rd_data_r <= 16'h0000;
        end else if (i_rd_cmd == ILR_HOST_CAP_OFS) begin
            rd_data_r <= {1'b0, host_cap_r, 8'h00}; // [RULE4]
        end else if (i_rd_cmd == ILR_APPLIED_CAP_OFS) begin
            rd_data_r <= {1'b0, applied_cap_r, 8'h00}; // [RULE5] [RULE7]
        end else if (i_rd_cmd == ILR_VIN_FLOOR_OFS) begin
            rd_data_r <= {2'b00, vin_code_r, 6'h00};
        end else begin
            rd_data_r <= 16'h0000;
        end
    end

    // Weighted decoders share one structure for current and voltage
    ilr_weight_sum #(.W(7)) u_cur (
        .i_code(applied_cap_r),
        .i_lsb_weight(ILR_CUR_STEP_MA),
        .i_offset(ILR_CUR_OFS_MA), // [RULE8]
        .o_value(cap_ma_nxt)
    );
    ilr_weight_sum #(.W(8)) u_vin (
        .i_code(vin_code_r),
        .i_lsb_weight(ILR_VIN_STEP_MV),
        .i_offset(ILR_VIN_OFS_MV), // [RULE10]
        .o_value(floor_prog_mv)
    );

    // Default floor tracks the unloaded supply; floored at zero to avoid wrap
    always_comb begin
        if (vin_set_r) begin
            floor_mv_nxt = floor_prog_mv;
        end else if (i_vsupply_noload_mv > ILR_VIN_DEFAULT_DROP_MV) begin
            floor_mv_nxt = i_vsupply_noload_mv - ILR_VIN_DEFAULT_DROP_MV; // [RULE11]
        end else begin
            floor_mv_nxt = 16'h0000;
        end
    end

    // Effective limits, one cycle after the write lands
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cap_ma_r <= 16'h0000;
            floor_mv_r <= 16'h0000;
        end else begin
            cap_ma_r <= cap_ma_nxt; // [RULE15]
            floor_mv_r <= floor_mv_nxt; // [RULE15]
        end
    end

    // Power management when the supply sags below the floor
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pm_r <= 1'b0;
        end else begin
            pm_r <= i_vsupply_mv < floor_mv_r; // [RULE12]
        end
    end

    assign o_rd_data = rd_data_r;
    assign o_wr_invalid = invalid_r;
    assign o_current_cap_ma = cap_ma_r;
    assign o_vin_floor_mv = floor_mv_r;
    assign o_power_mgmt_active = pm_r;

    a_host_reset: assert property (@(posedge i_mclk)
        !i_rst_n |=> host_cap_r == 7'h40) else $error("host cap reset wrong"); // [RULE2]
    a_rsv_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_host && i_wr_data[15] && !i_opt_valid && !(adapter_r && !i_adapter_present)
        |=> $stable(host_cap_r) && o_wr_invalid) else $error("reserved write taken"); // [RULE3]
    a_host_store: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_host && host_ok && !(adapter_r && !i_adapter_present)
        |=> host_cap_r == $past(i_wr_data[14:8])) else $error("host cap not stored"); // [RULE1]
    a_low_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_rd_cmd == 8'h3f |=> o_rd_data[7:0] == 8'h00 && !o_rd_data[15])
        else $error("reserved bits read nonzero"); // [RULE4]
    a_opt_apply: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_opt_valid && !wr_host && !(adapter_r && !i_adapter_present)
        |=> applied_cap_r == $past(i_opt_code) && $stable(host_cap_r))
        else $error("optimizer value not applied"); // [RULE6]
    a_cap_scale: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ##1 1'b1 |-> o_current_cap_ma == 16'(50 + 50 * $past(applied_cap_r)))
        else $error("current cap scaling wrong"); // [RULE8]
    a_floor_scale: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        vin_set_r |=> o_vin_floor_mv == 16'(3200 + 64 * $past(vin_code_r)))
        else $error("voltage floor scaling wrong"); // [RULE10]
    a_adapter_gone: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        adapter_r && !i_adapter_present |=> host_cap_r == 7'h40)
        else $error("cap not restored on adapter removal"); // [RULE14]
    a_pm_enter: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_vsupply_mv < floor_mv_r |=> o_power_mgmt_active)
        else $error("power management not entered"); // [RULE12]
    // Guards for the floor register, the read-only cap and leaving power management
    a_applied_reset: assert property (@(posedge i_mclk)
        !i_rst_n |=> applied_cap_r == ILR_APPLIED_CAP_RST) else $error("applied cap reset wrong"); // [RULE7]
    a_applied_ro: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_wr_en && i_wr_cmd == ILR_APPLIED_CAP_OFS && !i_opt_valid |=> $stable(applied_cap_r))
        else $error("read-only cap written"); // [RULE7]
    a_vin_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_vin && !vin_ok |=> $stable(vin_code_r) && o_wr_invalid)
        else $error("reserved floor write taken"); // [RULE3]
    a_vin_store: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_vin && vin_ok |=> vin_code_r == $past(i_wr_data[13:6]))
        else $error("floor code not stored"); // [RULE9]
    a_floor_default: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !vin_set_r && i_vsupply_noload_mv > ILR_VIN_DEFAULT_DROP_MV
        |=> o_vin_floor_mv == 16'($past(i_vsupply_noload_mv) - ILR_VIN_DEFAULT_DROP_MV))
        else $error("default floor wrong"); // [RULE11]
    a_pm_exit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_vsupply_mv >= floor_mv_r |=> !o_power_mgmt_active)
        else $error("power management not left"); // [RULE12]
endmodule : ilr_regs
`default_nettype wire

// ==== tb/ilr_host_model.sv ====
// Host-side model that issues whole-word register writes and reads
`timescale 1ns/10ps
`default_nettype none
module ilr_host_model (
    input wire logic i_mclk,
    output logic o_wr_en,
    output logic [7:0] o_wr_cmd,
    output logic [15:0] o_wr_data,
    output logic [7:0] o_rd_cmd,
    input wire logic [15:0] i_rd_data
);
    // Idle values before the first request
    initial begin
        o_wr_en = 1'b0;
        o_wr_cmd = 8'h00;
        o_wr_data = 16'h0000;
        o_rd_cmd = 8'h00;
    end
    // One complete 16-bit word per write, strobe held over one edge
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        o_wr_en = 1'b1;
        o_wr_cmd = c;
        o_wr_data = d;
        @(negedge i_mclk);
        o_wr_en = 1'b0;
        o_wr_data = ~d; // Stale data is scrambled once released
    endtask : wr
    // Readback is registered on the same rising edge that samples the index, and is read at the falling edge after it
    task automatic rd(input logic [7:0] c, output logic [15:0] q);
        o_rd_cmd = c;
        @(negedge i_mclk);
        q = i_rd_data;
    endtask : rd
endmodule : ilr_host_model
`default_nettype wire

// ==== tb/ilr_regs_tb.sv ====
// Self-checking bench for the input limit register set
`timescale 1ns/10ps
`default_nettype none
module ilr_regs_tb;
    import ilr_pkg::*;
    logic i_mclk, i_rst_n, wr_en, opt_valid, adapter, wr_inv, pm;
    logic [7:0] wr_cmd, rd_cmd;
    logic [6:0] opt_code;
    logic [15:0] wr_data, rd_data, cap_ma, floor_mv, noload, vsup, q;
    int n_fail = 0;
    int samples_checked = 0;
    ilr_host_model ilr_host_model_i (.i_mclk(i_mclk), .o_wr_en(wr_en), .o_wr_cmd(wr_cmd),
        .o_wr_data(wr_data), .o_rd_cmd(rd_cmd), .i_rd_data(rd_data));
    ilr_regs ilr_regs_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr_en(wr_en),
        .i_wr_cmd(wr_cmd), .i_wr_data(wr_data), .i_rd_cmd(rd_cmd), .o_rd_data(rd_data),
        .o_wr_invalid(wr_inv), .i_opt_valid(opt_valid), .i_opt_code(opt_code),
        .i_adapter_present(adapter), .i_vsupply_noload_mv(noload), .i_vsupply_mv(vsup),
        .o_current_cap_ma(cap_ma), .o_vin_floor_mv(floor_mv), .o_power_mgmt_active(pm));
    // 100 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    // Whole run needs about 55 cycles; a hang is cut well beyond that
    initial begin
        #20000;
        n_fail++;
        finish_test;
    end
    // Two parties on the same index must agree: host cap, applied cap, floor
    initial begin
        i_rst_n = 1'b0;
        opt_valid = 1'b0;
        opt_code = 7'h00;
        adapter = 1'b1;
        noload = 16'h2ee0; // 12000 mV
        vsup = 16'h3a98; // 15000 mV
        repeat (20) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_mclk);
        chk("cap_ma", cap_ma, ILR_CUR_OFS_MA);
        chk("floor", floor_mv, 16'h29e0);
        chk("pm", {15'h0000, pm}, 16'h0000);
        ilr_host_model_i.rd(ILR_HOST_CAP_OFS, q);
        chk("host", q, 16'h4000);
        ilr_host_model_i.rd(ILR_APPLIED_CAP_OFS, q);
        chk("applied", q, 16'h0000);
        ilr_host_model_i.rd(8'h10, q);
        chk("unmapped", q, 16'h0000);
        // Low reserved bits carry junk; only the field may land
        ilr_host_model_i.wr(ILR_HOST_CAP_OFS, 16'h20ff);
        ilr_host_model_i.rd(ILR_HOST_CAP_OFS, q);
        chk("host", q, 16'h2000);
        chk("cap_ma", cap_ma, 16'h0672);
        chk("inv", {15'h0000, wr_inv}, 16'h0000);
        ilr_host_model_i.rd(ILR_APPLIED_CAP_OFS, q);
        chk("applied", q, 16'h2000);
        // Reserved top bit set: write must be refused
        ilr_host_model_i.wr(ILR_HOST_CAP_OFS, 16'hc100);
        chk("inv", {15'h0000, wr_inv}, 16'h0001);
        ilr_host_model_i.rd(ILR_HOST_CAP_OFS, q);
        chk("host", q, 16'h2000);
        chk("inv", {15'h0000, wr_inv}, 16'h0000);
        ilr_host_model_i.wr(ILR_APPLIED_CAP_OFS, 16'h7f00);
        ilr_host_model_i.rd(ILR_APPLIED_CAP_OFS, q);
        chk("applied", q, 16'h2000);
        // Floor at full code lies above the supply
        ilr_host_model_i.wr(ILR_VIN_FLOOR_OFS, 16'h3fff);
        ilr_host_model_i.rd(ILR_VIN_FLOOR_OFS, q);
        chk("floor_reg", q, 16'h3fc0);
        chk("floor", floor_mv, 16'h4c40);
        repeat (2) @(negedge i_mclk);
        chk("pm", {15'h0000, pm}, 16'h0001);
        ilr_host_model_i.wr(ILR_VIN_FLOOR_OFS, 16'h4000);
        chk("inv", {15'h0000, wr_inv}, 16'h0001);
        ilr_host_model_i.rd(ILR_VIN_FLOOR_OFS, q);
        chk("floor_reg", q, 16'h3fc0);
        ilr_host_model_i.wr(ILR_VIN_FLOOR_OFS, 16'h0000);
        repeat (3) @(negedge i_mclk);
        chk("floor", floor_mv, ILR_VIN_OFS_MV);
        chk("pm", {15'h0000, pm}, 16'h0000);
        // Optimizer result overrides the applied cap only
        opt_code = 7'h05;
        opt_valid = 1'b1;
        @(negedge i_mclk);
        opt_valid = 1'b0;
        ilr_host_model_i.rd(ILR_APPLIED_CAP_OFS, q);
        chk("applied", q, 16'h0500);
        chk("cap_ma", cap_ma, 16'h012c);
        ilr_host_model_i.rd(ILR_HOST_CAP_OFS, q);
        chk("host", q, 16'h2000);
        adapter = 1'b0;
        @(negedge i_mclk);
        ilr_host_model_i.rd(ILR_HOST_CAP_OFS, q);
        chk("host", q, 16'h4000);
        adapter = 1'b1;
        // Mid-run reset must restore both caps and the default floor
        ilr_host_model_i.wr(ILR_HOST_CAP_OFS, 16'h1000);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        ilr_host_model_i.rd(ILR_HOST_CAP_OFS, q);
        chk("host", q, 16'h4000);
        ilr_host_model_i.rd(ILR_APPLIED_CAP_OFS, q);
        chk("applied", q, 16'h0000);
        chk("cap_ma", cap_ma, ILR_CUR_OFS_MA);
        chk("floor", floor_mv, 16'h29e0);
        finish_test;
    end
endmodule : ilr_regs_tb
`default_nettype wire
